// [sysctl2_cfg.svh]
// Offsets, field positions, reset values and timing constants of the second system control register.
`ifndef SYSCTL2_CFG_SVH
`define SYSCTL2_CFG_SVH
`define SC2_ADDR_SYSCTL      12'h0000
`define SC2_ADDR_STATUS      12'h0004
`define SC2_BIT_UART2_EN     8
`define SC2_BIT_SSP2_MASTER  9
`define SC2_BIT_SNZ_POL      10
`define SC2_BIT_SNZ_FETCH    11
`define SC2_BIT_RESERVED12   12
`define SC2_BIT_CLK_PIN_SEL  13
`define SC2_BIT_BUZ_SEL      14
`define SC2_RESET_LOW        8'h00
`define SC2_RESET_UPPER      7'h00
`define SC2_CLK_HZ           125000000
`define SC2_BUZ_HZ           500
`define SC2_BUZ_HALF_CYCLES  (`SC2_CLK_HZ / (2 * `SC2_BUZ_HZ))
`define SC2_NIBBLE_ZERO      4'h0
`define SC2_NIBBLE_ONES      4'hF
`define AXI_RESP_OKAY        2'b00
`define AXI_RESP_SLVERR      2'b10
`endif

// [sysctl2_pkg.sv]
// Types shared by the second system control register block.
package sysctl2_pkg;
    typedef struct packed {
        logic        uart2Enable;
        logic        ssp2Master;
        logic        snoozePolarity;
        logic        snoozeFetch;
        logic        clockPinSelect;
        logic        buzzerSelect;
    } ctrl_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } wreq_s;
endpackage

// [buzzer_tone_gen.sv]
// Divider that makes the fixed 500 Hz buzzer tone as a square wave.
`timescale 1ns/1ps
`include "sysctl2_cfg.svh"
module buzzer_tone_gen #(
    parameter int HALF_CYCLES = `SC2_BUZ_HALF_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    output logic      toneOut
);
    logic [$clog2(HALF_CYCLES)-1:0] count_ff;
    wire logic                      wrapTick = (count_ff == ($clog2(HALF_CYCLES))'(HALF_CYCLES - 1));

    // Count half periods and toggle the tone at each wrap.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_ff <= '0;
            toneOut  <= 1'b0;
        end else if (wrapTick) begin
            count_ff <= '0;
            toneOut  <= ~toneOut;
        end else begin
            count_ff <= count_ff + 1'b1;
        end
    end
endmodule // buzzer_tone_gen

// [pin_sync2.sv]
// Two-flop synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second stage.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule // pin_sync2

// [system_control_two.sv]
// Upper control bits of the second system control register, reached over AXI4-Lite.
// Summary of operation
// - Bit 8 enables the second UART.
// - Bit 9 low slave, high master.
// - Bit 9 also sets serial pin directions.
// - Snooze, polarity low: blank nibble all zeros.
// - Snooze, polarity high: blank nibble all ones.
// - Polarity bit ignored in Operating State.
// - Fetch bit set by hardware on Snooze entry.
// - Fetch bit high: fetch SRAM at 1bpp.
// - SRAM writable by CPU while fetch bit set, outside Snooze.
// - Writing zero returns to frame buffer DMA.
// - Resync display at end of following frame.
// - CPU writes of one to fetch ignored.
// - Bit 13 picks clock-enable or run on pin.
// - Bit 14 zero: buzzer from timer one.
// - Bit 14 one: buzzer is 500 Hz.
`timescale 1ns/1ps
`include "sysctl2_cfg.svh"
module system_control_two #(
    parameter int BUZ_HALF_CYCLES = `SC2_BUZ_HALF_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // AXI4-Lite slave.
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Power state and display inputs from on-chip logic.
    input  wire logic        snoozeActive,
    input  wire logic        frameEnd,
    input  wire logic [3:0]  activeNibble,
    input  wire logic        blankPhase,
    input  wire logic        cpuSramWriteReq,
    // Pin-level inputs from outside the clock domain.
    input  wire logic        timerOneBuzzer,
    input  wire logic        runSignal,
    input  wire logic        clockGateOutput,
    // Control outputs.
    output logic             secondUartEnable,
    output logic             syncSerialTwoMaster,
    output logic [2:0]       syncSerialTwoPinOe,
    output logic [3:0]       displayDataNibble,
    output logic             displayFetchSram1bpp,
    output logic             displayFetchDma,
    output logic             displayResync,
    output logic             cpuSramWriteGrant,
    output logic             runClockPin,
    output logic             buzzerPin
);
    import sysctl2_pkg::*;

    // Control state and bus handshake registers.
    ctrl_s       ctrl_ff;
    logic [7:0]  lowBits_ff;
    logic        reserved12_ff;
    logic        snoozeDelay_ff;
    logic        resyncArmed_ff;
    logic        awHeld_ff;
    logic        wHeld_ff;
    wreq_s       wReq_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    // Pin synchroniser and tone generator outputs.
    logic [2:0]  pinSync;
    logic        toneOut;

    // Register field encode, used by read decode.
    function automatic logic [15:0] pack_reg(input ctrl_s c, input logic r12, input logic [7:0] lo);
        logic [15:0] v;
        v = 16'h0000;
        v[7:0] = lo;
        v[`SC2_BIT_UART2_EN]    = c.uart2Enable;
        v[`SC2_BIT_SSP2_MASTER] = c.ssp2Master;
        v[`SC2_BIT_SNZ_POL]     = c.snoozePolarity;
        v[`SC2_BIT_SNZ_FETCH]   = c.snoozeFetch;
        v[`SC2_BIT_RESERVED12]  = r12;
        v[`SC2_BIT_CLK_PIN_SEL] = c.clockPinSelect;
        v[`SC2_BIT_BUZ_SEL]     = c.buzzerSelect;
        return v;
    endfunction

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
        return a[11:2] == target[11:2];
    endfunction

    // Synchronise outside-domain pin inputs before use.
    pin_sync2 #(.WIDTH(3)) u_pin_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .asyncIn ({timerOneBuzzer, runSignal, clockGateOutput}),
        .syncOut (pinSync)
    );

    // Fixed tone generator for the buzzer.
    buzzer_tone_gen #(.HALF_CYCLES(BUZ_HALF_CYCLES)) u_tone (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .toneOut (toneOut)
    );

    // Write channel decode: a write fires once address and data are each either held or taken this cycle.
    wire logic        awTake     = s_axi_awvalid & s_axi_awready;
    wire logic        wTake      = s_axi_wvalid & s_axi_wready;
    wire logic        awHave     = awHeld_ff | awTake;
    wire logic        wHave      = wHeld_ff | wTake;
    wire logic        wrFire     = awHave & wHave;
    wire logic [11:0] wrAddr     = awHeld_ff ? wReq_ff.addr : s_axi_awaddr;
    wire logic [31:0] wrData     = wHeld_ff ? wReq_ff.data : s_axi_wdata;
    wire logic [3:0]  wrStrb     = wHeld_ff ? wReq_ff.strb : s_axi_wstrb;
    wire logic        wrCtrl     = wrFire & addr_hit(wrAddr, `SC2_ADDR_SYSCTL);
    wire logic        wrStatus   = wrFire & addr_hit(wrAddr, `SC2_ADDR_STATUS);
    wire logic        wrLoLane   = wrCtrl & wrStrb[0];
    wire logic        wrHiLane   = wrCtrl & wrStrb[1];
    wire logic        clrFetch   = wrHiLane & ~wrData[`SC2_BIT_SNZ_FETCH];
    wire logic        snoozeRise = snoozeActive & ~snoozeDelay_ff;

    // Read channel decode.
    wire logic        rdTake     = s_axi_arvalid & s_axi_arready;
    wire logic        rdCtrl     = addr_hit(s_axi_araddr, `SC2_ADDR_SYSCTL);
    wire logic        rdStatus   = addr_hit(s_axi_araddr, `SC2_ADDR_STATUS);
    wire logic [31:0] statusWord = {28'h000_0000, resyncArmed_ff, snoozeActive,
                                    displayFetchDma, ctrl_ff.snoozeFetch};
    wire logic [31:0] rdWord     = rdCtrl ? {16'h0000, pack_reg(ctrl_ff, reserved12_ff, lowBits_ff)}
                                          : (rdStatus ? statusWord : 32'h0000_0000);

    // Next control values.
    ctrl_s nxt_ctrl;
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wrHiLane) begin
            nxt_ctrl.uart2Enable    = wrData[`SC2_BIT_UART2_EN];
            nxt_ctrl.ssp2Master     = wrData[`SC2_BIT_SSP2_MASTER];
            nxt_ctrl.snoozePolarity = wrData[`SC2_BIT_SNZ_POL];
            nxt_ctrl.clockPinSelect = wrData[`SC2_BIT_CLK_PIN_SEL];
            nxt_ctrl.buzzerSelect   = wrData[`SC2_BIT_BUZ_SEL];
        end
        // Hardware set on snooze entry wins over a clearing write.
        if (snoozeRise) begin
            nxt_ctrl.snoozeFetch = 1'b1;
        end else if (clrFetch) begin
            nxt_ctrl.snoozeFetch = 1'b0;
        end
    end

    // Register storage.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_ff        <= '0;
            lowBits_ff     <= `SC2_RESET_LOW;
            reserved12_ff  <= 1'b0;
            snoozeDelay_ff <= 1'b0;
        end else begin
            ctrl_ff        <= nxt_ctrl;
            snoozeDelay_ff <= snoozeActive;
            if (wrLoLane) begin
                lowBits_ff <= wrData[7:0];
            end
            if (wrHiLane) begin
                reserved12_ff <= wrData[`SC2_BIT_RESERVED12];
            end
        end
    end

    // Resync is armed by the clearing write and fires at the second frame end.
    logic       nxt_resyncArmed;
    logic       nxt_resyncSeen;
    logic       resyncSeen_ff;
    assign nxt_resyncArmed = clrFetch ? 1'b1 : ((resyncArmed_ff & resyncSeen_ff & frameEnd) ? 1'b0 : resyncArmed_ff);
    assign nxt_resyncSeen  = clrFetch ? 1'b0 : ((resyncArmed_ff & frameEnd) ? 1'b1 : resyncSeen_ff);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            resyncArmed_ff <= 1'b0;
            resyncSeen_ff  <= 1'b0;
            displayResync  <= 1'b0;
        end else begin
            resyncArmed_ff <= nxt_resyncArmed;
            resyncSeen_ff  <= nxt_resyncSeen & nxt_resyncArmed;
            displayResync  <= ~clrFetch & resyncArmed_ff & resyncSeen_ff & frameEnd;
        end
    end

    // Display and pin output selection.
    wire logic [3:0] blankNibble = ctrl_ff.snoozePolarity ? `SC2_NIBBLE_ONES : `SC2_NIBBLE_ZERO;
    wire logic       useBlank    = snoozeActive & blankPhase;
    wire logic [3:0] nxt_nibble  = useBlank ? blankNibble : activeNibble;
    wire logic       nxt_pin     = ctrl_ff.clockPinSelect ? pinSync[1] : pinSync[0];
    wire logic       nxt_buzzer  = ctrl_ff.buzzerSelect ? toneOut : pinSync[2];

    // Registered control outputs.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            secondUartEnable     <= 1'b0;
            syncSerialTwoMaster  <= 1'b0;
            syncSerialTwoPinOe   <= 3'b000;
            displayDataNibble    <= `SC2_NIBBLE_ZERO;
            displayFetchSram1bpp <= 1'b0;
            displayFetchDma      <= 1'b1;
            cpuSramWriteGrant    <= 1'b0;
            runClockPin          <= 1'b0;
            buzzerPin            <= 1'b0;
        end else begin
            secondUartEnable     <= ctrl_ff.uart2Enable;
            syncSerialTwoMaster  <= ctrl_ff.ssp2Master;
            syncSerialTwoPinOe   <= {3{ctrl_ff.ssp2Master}};
            displayDataNibble    <= nxt_nibble;
            displayFetchSram1bpp <= ctrl_ff.snoozeFetch;
            displayFetchDma      <= ~ctrl_ff.snoozeFetch;
            cpuSramWriteGrant    <= cpuSramWriteReq & ctrl_ff.snoozeFetch & ~snoozeActive;
            runClockPin          <= nxt_pin;
            buzzerPin            <= nxt_buzzer;
        end
    end

    // AXI4-Lite write handshake and response.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            wReq_ff   <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `AXI_RESP_OKAY;
        end else begin
            if (wrFire) begin
                awHeld_ff <= 1'b0;
                wHeld_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (wrCtrl | wrStatus) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else begin
                if (awTake) begin
                    awHeld_ff    <= 1'b1;
                    wReq_ff.addr <= s_axi_awaddr;
                end
                if (wTake) begin
                    wHeld_ff     <= 1'b1;
                    wReq_ff.data <= s_axi_wdata;
                    wReq_ff.strb <= s_axi_wstrb;
                end
                if (bvalid_ff & s_axi_bready) begin
                    bvalid_ff <= 1'b0;
                end
            end
        end
    end

    // AXI4-Lite read handshake.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `AXI_RESP_OKAY;
        end else if (rdTake) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rdWord;
            rresp_ff  <= (rdCtrl | rdStatus) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (rvalid_ff & s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Next handshake state; ready is registered from it so a channel is open only while its beat can be held.
    wire logic nxt_awHeld = ~wrFire & (awHeld_ff | awTake);
    wire logic nxt_wHeld  = ~wrFire & (wHeld_ff | wTake);
    wire logic nxt_bvalid = wrFire | (bvalid_ff & ~s_axi_bready);
    wire logic nxt_rvalid = rdTake | (rvalid_ff & ~s_axi_rready);

    // Ready outputs open after reset and close while a beat is held or a response waits.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= ~nxt_awHeld & ~nxt_bvalid;
            s_axi_wready  <= ~nxt_wHeld & ~nxt_bvalid;
            s_axi_arready <= ~nxt_rvalid;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;
endmodule // system_control_two

// [system_control_two_asserts.sv]
// Port-level assertions and covers for the second system control register block.
`timescale 1ns/1ps
module system_control_two_asserts #(
    parameter int BUZ_HALF_CYCLES = 10
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        snoozeActive,
    input wire logic        blankPhase,
    input wire logic [3:0]  activeNibble,
    input wire logic        cpuSramWriteReq,
    input wire logic        syncSerialTwoMaster,
    input wire logic [2:0]  syncSerialTwoPinOe,
    input wire logic [3:0]  displayDataNibble,
    input wire logic        displayFetchSram1bpp,
    input wire logic        displayFetchDma,
    input wire logic        displayResync,
    input wire logic        cpuSramWriteGrant
);
    // All checks run on the system clock and rest while reset is held.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("Write response missing after write taken.");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped before acceptance.");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data missing after address taken.");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data changed before acceptance.");
    pin_dir_a: assert property (syncSerialTwoPinOe == {3{syncSerialTwoMaster}})
        else $error("Serial pin directions disagree with role.");
    snz_fetch_a: assert property ($rose(snoozeActive) |-> ##[1:3] displayFetchSram1bpp)
        else $error("Fetch bit not set on snooze entry.");
    snz_hold_a: assert property (snoozeActive [*4] |-> displayFetchSram1bpp)
        else $error("SRAM fetch off while snoozing.");
    blank_nib_a: assert property (snoozeActive && blankPhase |=> displayDataNibble inside {4'h0, 4'hF})
        else $error("Blanked snooze nibble is not uniform.");
    op_nib_a: assert property (!snoozeActive |=> displayDataNibble == $past(activeNibble))
        else $error("Operating nibble does not follow display data.");
    sram_gnt_a: assert property (cpuSramWriteGrant |-> $past(cpuSramWriteReq) && !$past(snoozeActive))
        else $error("SRAM grant without request or during snooze.");
    resync_pulse_a: assert property (displayResync |=> !displayResync)
        else $error("Resync lasts longer than one cycle.");
    resync_dma_a: assert property (displayResync |-> displayFetchDma)
        else $error("Resync while not fetching by DMA.");

    // Main scenarios reached by the bench.
    cover property (snoozeActive && blankPhase);
    cover property (cpuSramWriteGrant);
    cover property (displayResync);
endmodule // system_control_two_asserts

bind system_control_two system_control_two_asserts #(.BUZ_HALF_CYCLES(BUZ_HALF_CYCLES)) chk_u (.clk_sys, .sys_rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .snoozeActive, .blankPhase, .activeNibble,
    .cpuSramWriteReq, .syncSerialTwoMaster, .syncSerialTwoPinOe, .displayDataNibble, .displayFetchSram1bpp,
    .displayFetchDma, .displayResync, .cpuSramWriteGrant);

// [tb_top.sv]
// Self-checking bench for the second system control register block.
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] CTRL = 12'h000;
    localparam logic [11:0] STAT = 12'h004;
    localparam logic [1:0]  OKAY = 2'b00;
    localparam logic [1:0]  SLVE = 2'b10;
    logic clk_sys = 1'b0, sys_rst = 1'b1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = '0, activeNibble = 4'h0, displayDataNibble;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  syncSerialTwoPinOe;
    // Response ready lines stay high, so every response is taken at the edge where it is first seen.
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
    logic snoozeActive = 0, frameEnd = 0, blankPhase = 0, cpuSramWriteReq = 0;
    logic timerOneBuzzer = 0, runSignal = 1, clockGateOutput = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic secondUartEnable, syncSerialTwoMaster, displayFetchSram1bpp, displayFetchDma;
    logic displayResync, cpuSramWriteGrant, runClockPin, buzzerPin, prevBuz;
    int errors = 0, nCompared = 0, cycles = 0, resyncs = 0, base = 0, edges = 0;

    system_control_two #(.BUZ_HALF_CYCLES(10)) dut_u (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .snoozeActive, .frameEnd, .activeNibble, .blankPhase, .cpuSramWriteReq, .timerOneBuzzer,
        .runSignal, .clockGateOutput, .secondUartEnable, .syncSerialTwoMaster, .syncSerialTwoPinOe,
        .displayDataNibble, .displayFetchSram1bpp, .displayFetchDma, .displayResync, .cpuSramWriteGrant,
        .runClockPin, .buzzerPin);

    // Clock at 125 MHz.
    always #4 clk_sys = ~clk_sys;

    // Counts resync pulses and cuts a hang short.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (displayResync === 1'b1) resyncs <= resyncs + 1;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end

    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits a number of clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One write: address and data offered together, each released when taken.
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        logic awOk;
        logic wOk;
        awOk = 1'b0;
        wOk = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(awOk && wOk)) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                awOk = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                wOk = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        chk("bresp", s_axi_bresp, r);
    endtask

    // One read, checked against the expected data and response.
    task automatic axiRd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r, input string what);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        chk(what, s_axi_rdata, d);
        chk("rresp", s_axi_rresp, r);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("Counts: %0d compared, %0d mismatched", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence of tests.
    initial begin
        tick(20);
        sys_rst <= 1'b0;
        tick(2);
        chk("fetchDma", displayFetchDma, 1);
        chk("uartEn", secondUartEnable, 0);
        axiRd(CTRL, 32'h0000_0000, OKAY, "ctrl");
        axiRd(STAT, 32'h0000_0002, OKAY, "status");
        $display("Test reset done");
        axiWr(CTRL, 32'h0000_6F00, 4'hF, OKAY);
        tick(4);
        axiRd(CTRL, 32'h0000_6700, OKAY, "ctrl");
        chk("uartEn", secondUartEnable, 1);
        chk("master", syncSerialTwoMaster, 1);
        chk("pinOe", syncSerialTwoPinOe, 3'b111);
        chk("runPin", runClockPin, 1);
        chk("fetchSram", displayFetchSram1bpp, 0);
        prevBuz = buzzerPin;
        repeat (40) begin
            @(posedge clk_sys);
            if (buzzerPin !== prevBuz) edges++;
            prevBuz = buzzerPin;
        end
        chk("buzEdges", edges, 4);
        axiWr(CTRL, 32'h0000_80FF, 4'h1, OKAY);
        axiRd(CTRL, 32'h0000_67FF, OKAY, "ctrlLane");
        timerOneBuzzer <= 1'b1;
        axiWr(CTRL, 32'h0000_0000, 4'hF, OKAY);
        tick(4);
        chk("uartEn", secondUartEnable, 0);
        chk("master", syncSerialTwoMaster, 0);
        chk("pinOe", syncSerialTwoPinOe, 3'b000);
        chk("runPin", runClockPin, 0);
        chk("buzzer", buzzerPin, 1);
        $display("Test control bits done");
        axiWr(12'h010, 32'hFFFF_FFFF, 4'hF, SLVE);
        axiRd(12'h010, 32'h0000_0000, SLVE, "unmapped");
        axiRd(CTRL, 32'h0000_0000, OKAY, "ctrl");
        $display("Test unmapped done");
        activeNibble <= 4'hA;
        blankPhase <= 1'b1;
        snoozeActive <= 1'b1;
        tick(4);
        chk("nibble", displayDataNibble, 4'h0);
        chk("fetchSram", displayFetchSram1bpp, 1);
        axiRd(CTRL, 32'h0000_0800, OKAY, "ctrlSnz");
        axiWr(CTRL, 32'h0000_0C00, 4'hF, OKAY);
        tick(4);
        chk("nibble", displayDataNibble, 4'hF);
        snoozeActive <= 1'b0;
        cpuSramWriteReq <= 1'b1;
        tick(4);
        chk("nibble", displayDataNibble, 4'hA);
        chk("grant", cpuSramWriteGrant, 1);
        chk("fetchSram", displayFetchSram1bpp, 1);
        base = resyncs;
        axiWr(CTRL, 32'h0000_0400, 4'hF, OKAY);
        tick(3);
        chk("fetchDma", displayFetchDma, 1);
        chk("fetchSram", displayFetchSram1bpp, 0);
        chk("grant", cpuSramWriteGrant, 0);
        repeat (2) begin
            frameEnd <= 1'b1;
            tick(1);
            frameEnd <= 1'b0;
            tick(5);
            chk("resyncs", resyncs - base, edges - 4);
            edges++;
        end
        $display("Test snooze done");
        wrap_up();
    end
endmodule // tb_top
